// file: fepc_top.v
`timescale 1ns/100ps
`include "fepc_defines.vh"
module fepc_top #(
  parameter AW          = 8,
  parameter NOT_BLANK_VIOLATION_CYCLES = 4
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          ce,
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  input  wire          fl_valid,
  output wire          fl_ready,
  input  wire          fl_write,
  input  wire          fl_fetch,
  input  wire [1:0]    fl_size,
  input  wire [14:0]   fl_addr,
  input  wire [31:0]   fl_wdata,
  output reg  [31:0]   fl_rdata,
  output reg           fl_rvalid,
  output reg           fl_fault,
  input  wire [14:0]   pc_addr,
  input  wire          pc_in_flash,
  output wire          irq
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_NOT_BLANK_VIOLATION  = 3'b100;

  reg  [31:0]              mem [0:`FEPC_WORDS-1];
  reg  [`FEPC_MODE_W-1:0]  mode;
  reg  [`FEPC_WAIT_W-1:0]  wait_code;
  reg  [`FEPC_GROUPS-1:0]  unlock;
  reg  [`FEPC_EV_W-1:0]    enables;
  reg  [`FEPC_EV_W-1:0]    flags;
  reg  [2:0]               state;
  reg  [2:0]               next_state;
  reg  [6:0]               ecnt;
  reg  [5:0]               epage;
  reg  [15:0]              pcnt;
  reg  [12:0]              pword;
  reg  [31:0]              pdata;
  reg  [31:0]              pmask;
  reg  [AW-1:0]            aw_addr;
  reg                      aw_held;
  reg  [31:0]              w_data;
  reg  [3:0]               w_strb;
  reg                      w_held;
  reg  [31:0]              rd_word;
  reg                      rd_hit;
  integer                  i;

  wire                     busy;
  wire                     wdone;
  wire                     taken;
  wire                     bad;
  wire                     locked;
  wire                     pc_hit;
  wire [3:0]               lane;
  wire [31:0]              bmask;
  wire [12:0]              waddr;
  wire                     blank;
  wire                     trig;
  wire                     do_erase;
  wire                     do_not_blank_violation;
  wire [`FEPC_EV_W-1:0]    ev_set;
  wire [`FEPC_EV_W-1:0]    ev_clr;
  wire                     wr_go;
  wire                     key_ok;
  wire                     wr_ctrl_one;
  wire                     wr_lock;

  // no reset on the array; power-up content is treated as erased
  initial begin
    for (i = 0; i < `FEPC_WORDS; i = i + 1) begin
      mem[i] = `FEPC_ERASED_WORD;
    end
  end

  fepc_wait u_wait (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .req       (fl_valid && fl_fetch && !fl_write),
    .take      (taken),
    .wait_code (wait_code),
    .done      (wdone)
  );

  fepc_check u_check (
    .addr        (fl_addr),
    .size        (fl_size),
    .unlock      (unlock),
    .pc_addr     (pc_addr),
    .pc_in_flash (pc_in_flash),
    .bad         (bad),
    .locked      (locked),
    .pc_hit      (pc_hit),
    .lane        (lane)
  );

  assign busy  = (state != ST_IDLE);
  // reads stall while the array is being changed; writes are always taken
  assign fl_ready = (fl_write || !busy) &&
                    (fl_write || !fl_fetch || wdone);
  assign taken = ce && fl_valid && fl_ready;
  assign waddr = fl_addr[14:2];
  assign bmask = {{8{lane[3]}}, {8{lane[2]}}, {8{lane[1]}}, {8{lane[0]}}};
  assign blank = ((mem[waddr] & bmask) == bmask);

  // a trigger write is any aligned, in-range write while idle
  assign trig     = taken && fl_write && !bad && !busy;
  assign do_erase = trig && (mode == `FEPC_MODE_ERASE) &&
                    !locked && !pc_hit;
  assign do_not_blank_violation  = trig && (mode == `FEPC_MODE_NOT_BLANK_VIOLATION) &&
                    !locked && !pc_hit && blank;

  // lock first, then executing page, then blank check
  assign ev_set[`FEPC_EV_LOCK]  = trig && locked &&
                                  ((mode == `FEPC_MODE_ERASE) ||
                                   (mode == `FEPC_MODE_NOT_BLANK_VIOLATION));
  assign ev_set[`FEPC_EV_EXEC]  = trig && !locked && pc_hit &&
                                  ((mode == `FEPC_MODE_ERASE) ||
                                   (mode == `FEPC_MODE_NOT_BLANK_VIOLATION));
  assign ev_set[`FEPC_EV_BLANK] = trig && !locked && !pc_hit && !blank &&
                                  (mode == `FEPC_MODE_NOT_BLANK_VIOLATION);

  // operation sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (do_erase) begin
          next_state = ST_ERASE;
        end else if (do_not_blank_violation) begin
          next_state = ST_NOT_BLANK_VIOLATION;
        end
      end
      ST_ERASE: begin
        if (ecnt == `FEPC_PAGE_LAST_WORD) begin
          next_state = ST_IDLE;
        end
      end
      ST_NOT_BLANK_VIOLATION: begin
        if (pcnt == NOT_BLANK_VIOLATION_CYCLES[15:0] - 16'h1) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      ecnt  <= 7'h00;
      epage <= 6'h00;
      pcnt  <= 16'h0000;
      pword <= 13'h0000;
      pdata <= 32'h00000000;
      pmask <= 32'h00000000;
    end else if (ce) begin
      state <= next_state;
      if (state == ST_IDLE) begin
        ecnt  <= 7'h00;
        pcnt  <= 16'h0000;
        epage <= fl_addr[`FEPC_PAGE_HI:`FEPC_PAGE_LO];
        pword <= waddr;
        pdata <= fl_wdata;
        pmask <= bmask;
      end else begin
        ecnt <= ecnt + 7'h01;
        pcnt <= pcnt + 16'h0001;
      end
    end
  end

  // array writes: erase walks the page one word per cycle
  always @(posedge aclk) begin
    if (ce) begin
      if (state == ST_ERASE) begin
        mem[{epage, ecnt}] <= `FEPC_ERASED_WORD;
      end else if ((state == ST_NOT_BLANK_VIOLATION) && (next_state == ST_IDLE)) begin
        mem[pword] <= mem[pword] & (pdata | ~pmask);
      end
    end
  end

  // processor side answers
  always @(posedge aclk) begin
    if (!aresetn) begin
      fl_rdata  <= 32'h00000000;
      fl_rvalid <= 1'b0;
      fl_fault  <= 1'b0;
    end else if (ce) begin
      fl_rvalid <= taken && !fl_write && !bad;
      fl_fault  <= taken && bad;
      if (taken && !fl_write && !bad) begin
        fl_rdata <= mem[waddr];
      end
    end
  end

  // register slave
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign key_ok        = (w_strb == 4'hF) &&
                         (w_data[`FEPC_KEY_HI:`FEPC_KEY_LO] == `FEPC_KEY);
  assign wr_ctrl_one   = wr_go && key_ok &&
                         (aw_addr == `FEPC_OFS_CTRL_ONE);
  assign wr_lock       = wr_go && key_ok && (aw_addr == `FEPC_OFS_LOCK);
  assign ev_clr        = (wr_go && w_strb[0] &&
                          (aw_addr == `FEPC_OFS_CLEARS)) ?
                         ~w_data[`FEPC_EV_W-1:0] : `FEPC_EV_NONE;
  assign irq           = |(flags & enables);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      aw_addr      <= {AW{1'b0}};
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FEPC_RESP_OKAY;
      mode         <= `FEPC_MODE_READ;
      wait_code    <= `FEPC_WAIT_ZERO;
      unlock       <= {`FEPC_GROUPS{1'b0}};
      enables      <= `FEPC_EV_NONE;
      flags        <= `FEPC_EV_NONE;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `FEPC_OFS_CTRL_ONE,
          `FEPC_OFS_CTRL_TWO,
          `FEPC_OFS_LOCK,
          `FEPC_OFS_ENABLES,
          `FEPC_OFS_FLAGS,
          `FEPC_OFS_CLEARS: s_axi_bresp <= `FEPC_RESP_OKAY;
          default:          s_axi_bresp <= `FEPC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl_one) begin
        mode <= w_data[`FEPC_MODE_W-1:0];
      end
      if (wr_lock) begin
        unlock <= w_data[`FEPC_GROUPS-1:0];
      end
      if (wr_go && w_strb[0] && (aw_addr == `FEPC_OFS_CTRL_TWO)) begin
        wait_code <= w_data[`FEPC_WAIT_W-1:0];
      end
      if (wr_go && w_strb[0] && (aw_addr == `FEPC_OFS_ENABLES)) begin
        enables <= w_data[`FEPC_EV_W-1:0];
      end
      // a new event outranks a clear in the same cycle
      flags <= (flags & ~ev_clr) | ev_set;
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `FEPC_OFS_CTRL_ONE: begin
        rd_word[`FEPC_MODE_W-1:0] = mode;
        rd_word[`FEPC_BUSY_BIT]   = busy;
      end
      `FEPC_OFS_CTRL_TWO: rd_word[`FEPC_WAIT_W-1:0] = wait_code;
      `FEPC_OFS_LOCK:     rd_word[`FEPC_GROUPS-1:0] = unlock;
      `FEPC_OFS_ENABLES:  rd_word[`FEPC_EV_W-1:0]   = enables;
      `FEPC_OFS_FLAGS:    rd_word[`FEPC_EV_W-1:0]   = flags;
      `FEPC_OFS_CLEARS:   rd_word[`FEPC_EV_W-1:0]   = `FEPC_EV_ALL;
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FEPC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `FEPC_RESP_OKAY : `FEPC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // fepc_top

// file: fepc_defines.vh
`ifndef FEPC_DEFINES_VH
`define FEPC_DEFINES_VH

// register byte offsets
`define FEPC_OFS_CTRL_ONE   8'h00
`define FEPC_OFS_CTRL_TWO   8'h04
`define FEPC_OFS_LOCK       8'h08
`define FEPC_OFS_ENABLES    8'h0C
`define FEPC_OFS_FLAGS      8'h10
`define FEPC_OFS_CLEARS     8'h14

// key in the upper half of a protected write
`define FEPC_KEY            16'h5A5A
`define FEPC_KEY_HI         31
`define FEPC_KEY_LO         16

// operation mode codes
`define FEPC_MODE_W         2
`define FEPC_MODE_READ      2'h0
`define FEPC_MODE_NOT_BLANK_VIOLATION      2'h1
`define FEPC_MODE_ERASE     2'h2

// field positions
`define FEPC_BUSY_BIT       4
`define FEPC_WAIT_W         3
`define FEPC_WAIT_ZERO      3'h0
`define FEPC_WAIT_ONE       3'h1
`define FEPC_WAIT_TWO       3'h2

// event bits
`define FEPC_EV_W           3
`define FEPC_EV_LOCK        0
`define FEPC_EV_EXEC        1
`define FEPC_EV_BLANK       2
`define FEPC_EV_NONE        3'h0
`define FEPC_EV_ALL         3'h7

// array geometry
`define FEPC_GROUPS         10
`define FEPC_LAST_GROUP     4'h9
`define FEPC_FLASH_BYTES    15'h5000
`define FEPC_WORDS          5120
`define FEPC_PAGE_HI        14
`define FEPC_PAGE_LO        9
`define FEPC_GROUP_LO       11
`define FEPC_PAGE_LAST_WORD 7'h7F
`define FEPC_ERASED_WORD    32'hFFFFFFFF

// access sizes
`define FEPC_SIZE_BYTE      2'h0
`define FEPC_SIZE_HALF      2'h1
`define FEPC_SIZE_WORD      2'h2

// AXI responses
`define FEPC_RESP_OKAY      2'h0
`define FEPC_RESP_SLVERR    2'h2

`endif

// file: fepc_wait.v
`timescale 1ns/100ps
`include "fepc_defines.vh"
module fepc_wait (
  input  wire                    aclk,
  input  wire                    aresetn,
  input  wire                    ce,
  input  wire                    req,
  input  wire                    take,
  input  wire [`FEPC_WAIT_W-1:0] wait_code,
  output wire                    done
);
  reg  [1:0] cnt;
  wire [1:0] limit;

  // reserved codes fall back to the slowest setting
  assign limit = (wait_code == `FEPC_WAIT_ZERO) ? 2'h0 :
                 (wait_code == `FEPC_WAIT_ONE)  ? 2'h1 : 2'h2;
  assign done  = (cnt >= limit);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 2'h0;
    end else if (ce) begin
      if (take) begin
        cnt <= 2'h0;
      end else if (req && !done) begin
        cnt <= cnt + 2'h1;
      end
    end
  end
endmodule // fepc_wait

// file: fepc_check.v
`timescale 1ns/100ps
`include "fepc_defines.vh"
module fepc_check (
  input  wire [14:0]              addr,
  input  wire [1:0]               size,
  input  wire [`FEPC_GROUPS-1:0]  unlock,
  input  wire [14:0]              pc_addr,
  input  wire                     pc_in_flash,
  output wire                     bad,
  output wire                     locked,
  output wire                     pc_hit,
  output reg  [3:0]               lane
);
  wire [3:0] grp;
  wire       misalign;

  assign grp      = addr[`FEPC_PAGE_HI:`FEPC_GROUP_LO];
  assign misalign = ((size == `FEPC_SIZE_HALF) && addr[0]) ||
                    ((size == `FEPC_SIZE_WORD) && (addr[1:0] != 2'h0)) ||
                    (size > `FEPC_SIZE_WORD);
  assign bad      = misalign || (addr >= `FEPC_FLASH_BYTES);
  // each group bit covers four pages
  assign locked   = (grp > `FEPC_LAST_GROUP) || !unlock[grp];
  assign pc_hit   = pc_in_flash &&
                    (pc_addr[`FEPC_PAGE_HI:`FEPC_PAGE_LO] ==
                     addr[`FEPC_PAGE_HI:`FEPC_PAGE_LO]);

  always @* begin
    case (size)
      `FEPC_SIZE_BYTE: lane = 4'h1 << addr[1:0];
      `FEPC_SIZE_HALF: lane = addr[1] ? 4'hC : 4'h3;
      default:         lane = 4'hF;
    endcase
  end
endmodule // fepc_check

// file: fepc_monitor.sv
`timescale 1ns/100ps
module fepc_monitor #(
  parameter AW          = 8,
  parameter NOT_BLANK_VIOLATION_CYCLES = 4
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        fl_valid,
  input wire        fl_ready,
  input wire        fl_write,
  input wire        fl_fetch,
  input wire [1:0]  fl_size,
  input wire [14:0] fl_addr,
  input wire        fl_rvalid,
  input wire        fl_fault,
  input wire        irq
);
  // idle time since a flash write; an erase stalls fetches far longer
  reg  [7:0] gap;
  wire       take = fl_valid && fl_ready;
  always @(posedge aclk)
    if (!aresetn || (take && fl_write)) gap <= 8'h00;
    else if (!(&gap)) gap <= gap + 8'h01;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_fault;
    take && fl_size == 2'h2 && fl_addr[1:0] != 2'h0 |=> fl_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("no fault");
  property p_read;
    take && !fl_write && fl_size == 2'h2 && fl_addr[1:0] == 2'h0
      && fl_addr < 15'h5000 |=> fl_rvalid && !fl_fault;
  endproperty
  a_read: assert property (p_read) else $error("no read data");
  property p_fetch;
    $rose(fl_valid) && fl_fetch && !fl_write && gap > 8'hC8
      |-> ##[0:2] fl_ready;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch too slow");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer lost");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer lost");
  property p_blate;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_blate: assert property (p_blate) else $error("write answer timing");
  property p_rlate;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlate: assert property (p_rlate) else $error("read answer timing");
  property p_irq;
    $rose(aresetn) |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq after reset");
  c_fault: cover property (fl_fault);
  c_fetch: cover property (fl_valid && fl_fetch && !fl_ready);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // fepc_monitor

bind fepc_top fepc_monitor #(.AW(AW), .NOT_BLANK_VIOLATION_CYCLES(NOT_BLANK_VIOLATION_CYCLES)) u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .fl_valid, .fl_ready, .fl_write, .fl_fetch, .fl_size,
  .fl_addr, .fl_rvalid, .fl_fault, .irq
);

// file: fepc_core_model.sv
`timescale 1ns/100ps
module fepc_core_model (
  input  wire        aclk,
  input  wire        fl_ready,
  input  wire [31:0] fl_rdata,
  input  wire        fl_fault,
  output reg         fl_valid = 1'h0,
  output reg         fl_write = 1'h0,
  output reg         fl_fetch = 1'h0,
  output reg  [1:0]  fl_size = 2'h0,
  output reg  [14:0] fl_addr = 15'h0000,
  output reg  [31:0] fl_wdata = 32'h0
);
  task acc(input w, input f, input [1:0] sz, input [14:0] ad,
           input [31:0] d, input integer dly, output [31:0] q,
           output flt, output integer nw);
    begin
      repeat (dly) @(posedge aclk);
      @(posedge aclk);
      fl_valid <= 1'h1;
      fl_write <= w;
      fl_fetch <= f;
      fl_size <= sz;
      fl_addr <= ad;
      fl_wdata <= d;
      nw = 0;
      @(posedge aclk);
      while (!fl_ready) begin
        nw = nw + 1;
        @(posedge aclk);
      end
      fl_valid <= 1'h0;
      // released address and data lines flip so stale values are never trusted
      fl_addr <= ~ad;
      fl_wdata <= ~d;
      @(posedge aclk);
      q = fl_rdata;
      flt = fl_fault;
    end
  endtask
endmodule // fepc_core_model

// file: flash_erase_program_controller_bench.sv
`timescale 1ns/100ps
module flash_erase_program_controller_bench;
  reg         aclk = 1'h0;
  reg         aresetn = 1'h0;
  reg         awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
  reg         pc_in = 1'h0;
  reg  [7:0]  awa = 8'h00, ara = 8'h00;
  reg  [31:0] wd = 32'h0, q;
  reg  [14:0] pca = 15'h0000;
  reg  [1:0]  rs;
  reg         flt;
  reg  [73:0] row [0:7];
  integer     nw, i, n_mismatch = 0, checked = 0, stall = 0, k;
  wire        awr, wr, bv, arr, rv, flv, flr, flw, ffe, fft, irq;
  wire [1:0]  br, rr, fsz;
  wire [31:0] rdt, fwd, frd;
  wire [14:0] fad;
  fepc_top #(.AW(8), .NOT_BLANK_VIOLATION_CYCLES(4)) DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .fl_valid(flv), .fl_ready(flr), .fl_write(flw),
    .fl_fetch(ffe), .fl_size(fsz), .fl_addr(fad), .fl_wdata(fwd),
    .fl_rdata(frd), .fl_rvalid(), .fl_fault(fft), .pc_addr(pca),
    .pc_in_flash(pc_in), .irq(irq)
  );
  fepc_core_model core (
    .aclk(aclk), .fl_ready(flr), .fl_rdata(frd), .fl_fault(fft),
    .fl_valid(flv), .fl_write(flw), .fl_fetch(ffe), .fl_size(fsz),
    .fl_addr(fad), .fl_wdata(fwd)
  );
  always #10 aclk = ~aclk;
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task axw(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      // a late bready makes the slave hold its answer
      bre <= (stall == 0);
      k = 0;
      do begin
        @(posedge aclk);
        if (awr) awv <= 1'h0;
        if (wr) wv <= 1'h0;
        k = k + 1;
        if (k >= stall) bre <= 1'h1;
      end while (!(bv && bre));
      rs = br;
      bre <= 1'h0;
    end
  endtask
  task axr(input [7:0] a);
    begin
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      rre <= (stall == 0);
      k = 0;
      do begin
        @(posedge aclk);
        if (arr) arv <= 1'h0;
        k = k + 1;
        if (k >= stall) rre <= 1'h1;
      end while (!(rv && rre));
      q = rdt;
      rs = rr;
      rre <= 1'h0;
    end
  endtask
  task kw(input [7:0] a, input [15:0] v);
    axw(a, {16'h5A5A, v});
  endtask
  task rg(input [7:0] a, input [31:0] e);
    begin
      axr(a);
      chk("reg", e, q);
    end
  endtask
  task fa(input w, f, input [1:0] s, input [14:0] a, input [31:0] d);
    core.acc(w, f, s, a, d, 0, q, flt, nw);
  endtask
  task fl(input [14:0] a, input [31:0] e);
    begin
      fa(1'h0, 1'h0, 2'h2, a, 32'h0);
      chk("flash", e, q);
      chk("nofault", 1'h0, flt);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  initial begin
    row[0] = {8'h04, 32'h2, 32'h2, 2'h0};
    row[1] = {8'h0C, 32'h7, 32'h7, 2'h0};
    row[2] = {8'h08, 32'h123403FF, 32'h0, 2'h0};
    row[3] = {8'h08, 32'h5A5AFFFF, 32'h3FF, 2'h0};
    row[4] = {8'h00, 32'h2, 32'h0, 2'h0};
    row[5] = {8'h00, 32'h5A5A0001, 32'h1, 2'h0};
    row[6] = {8'h14, 32'h0, 32'h7, 2'h0};
    row[7] = {8'h18, 32'hFFFFFFFF, 32'h0, 2'h2};
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rg(8'h00, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      stall = i % 4;
      axw(row[i][73:66], row[i][65:34]);
      chk("bresp", row[i][1:0], rs);
      axr(row[i][73:66]);
      chk("rresp", row[i][1:0], rs);
      chk("rdata", row[i][33:2], q);
    end
    stall = 0;
    fa(1'h1, 1'h0, 2'h2, 15'h204, 32'h12345678);
    fl(15'h204, 32'h12345678);
    fa(1'h1, 1'h0, 2'h2, 15'h400, 32'h0);
    fl(15'h400, 32'h0);
    fa(1'h1, 1'h0, 2'h0, 15'h204, 32'h0);
    rg(8'h10, 32'h4);
    chk("irq", 1'h1, irq);
    axw(8'h14, 32'h3);
    rg(8'h10, 32'h0);
    chk("irq", 1'h0, irq);
    fa(1'h1, 1'h0, 2'h0, 15'h201, 32'h5500);
    fl(15'h200, 32'hFFFF55FF);
    fa(1'h1, 1'h0, 2'h1, 15'h20A, 32'hABCD0000);
    fl(15'h208, 32'hABCDFFFF);
    fa(1'h1, 1'h0, 2'h2, 15'h202, 32'h0);
    chk("fault", 1'h1, flt);
    fa(1'h0, 1'h0, 2'h1, 15'h203, 32'h0);
    chk("fault", 1'h1, flt);
    fa(1'h0, 1'h0, 2'h3, 15'h204, 32'h0);
    chk("fault", 1'h1, flt);
    fa(1'h0, 1'h0, 2'h2, 15'h5000, 32'h0);
    chk("fault", 1'h1, flt);
    kw(8'h08, 16'h0002);
    fa(1'h1, 1'h0, 2'h2, 15'h7FC, 32'h0);
    rg(8'h10, 32'h1);
    axw(8'h14, 32'h6);
    fa(1'h1, 1'h0, 2'h2, 15'h800, 32'h0);
    fl(15'h800, 32'h0);
    kw(8'h08, 16'h0001);
    pc_in <= 1'h1;
    pca <= 15'h0300;
    fa(1'h1, 1'h0, 2'h2, 15'h210, 32'h0);
    rg(8'h10, 32'h2);
    axw(8'h14, 32'h5);
    kw(8'h00, 16'h0002);
    fa(1'h1, 1'h0, 2'h2, 15'h200, 32'h0);
    rg(8'h10, 32'h2);
    axw(8'h14, 32'h5);
    pc_in <= 1'h0;
    fa(1'h1, 1'h0, 2'h2, 15'h3FC, 32'h0);
    rg(8'h00, 32'h12);
    // second trigger lands mid-erase and must be dropped
    fa(1'h1, 1'h0, 2'h2, 15'h400, 32'h0);
    fl(15'h204, 32'hFFFFFFFF);
    rg(8'h00, 32'h2);
    core.acc(1'h0, 1'h0, 2'h2, 15'h3FC, 32'h0, 5, q, flt, nw);
    chk("erased", 32'hFFFFFFFF, q);
    fl(15'h400, 32'h0);
    kw(8'h08, 16'h0000);
    fa(1'h1, 1'h0, 2'h2, 15'h200, 32'h0);
    rg(8'h10, 32'h1);
    axw(8'h14, 32'h6);
    kw(8'h00, 16'h0000);
    repeat (210) @(posedge aclk);
    // reserved code 3 must stall like the slowest setting
    for (i = 0; i < 4; i = i + 1) begin
      axw(8'h04, i);
      fa(1'h0, 1'h1, 2'h2, 15'h200, 32'h0);
      chk("wait", (i > 2) ? 2 : i, nw);
    end
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rg(8'h04, 32'h0);
    fl(15'h800, 32'h0);
    test_done;
  end
endmodule // flash_erase_program_controller_bench
